// *** sfm_startup_top.sv ***
// Purpose: Start-up sequencer: delay, mode sense window, mode latch, gate flip-flop
// Assumes: Comparator and level inputs are asynchronous pins
// Notes: APB slave with zero wait states; sticky interrupt status
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module sfm_startup_top
    import sfm_pkg::*;
#(
    parameter int SET_CYCLES = SET_CYC,
    parameter int DET_CYCLES = DET_CYC
)
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic SUPPLY_GOOD,
    input wire logic FB_SHORT,
    input wire logic PIN_ABOVE_LOW,
    input wire logic PIN_ABOVE_HIGH,
    input wire logic PWM_CMP,
    input wire logic [7:0] LINE_SENSE,
    input wire logic [7:0] MULT_OUT,
    output logic GATE_DRIVE,
    output logic SENSE_CURRENT_EN,
    output logic [1:0] FREQ_MODE,
    output logic IRQ
);
    localparam int NSYNC = 21;

    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] meta_reg;
    logic [NSYNC-1:0] sync_reg;
    logic sup_good;
    logic fb_short;
    logic above_low;
    logic above_high;
    logic pwm_cmp;

    sfm_state_t state_reg;
    sfm_state_t state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    sfm_mode_t mode_reg;
    logic mode_valid_reg;
    logic sense_reg;
    logic gate_reg;
    logic sup_good_d_reg;
    logic delay_done;
    logic sense_done;

    logic inhibit_reg;
    logic [EV_W-1:0] int_stat_reg;
    logic [EV_W-1:0] int_mask_reg;
    logic [EV_W-1:0] events;
    logic irq_reg;
    logic [31:0] prdata_reg;
    logic wr_access;
    logic rd_setup;
    logic mapped;

    sfm_osc_if osc_link();

    assign raw_in = {MULT_OUT, LINE_SENSE, PWM_CMP, PIN_ABOVE_HIGH, PIN_ABOVE_LOW,
                     FB_SHORT, SUPPLY_GOOD};

    // Level codes may tear across bits for one cycle; they only steer frequency
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge CLK) begin
                if (SYS_RST) begin
                    meta_reg[gi] <= 1'b0;
                    sync_reg[gi] <= 1'b0;
                end else begin
                    meta_reg[gi] <= raw_in[gi];
                    sync_reg[gi] <= meta_reg[gi];
                end
            end
        end
    endgenerate

    assign sup_good = sync_reg[0];
    assign fb_short = sync_reg[1];
    assign above_low = sync_reg[2];
    assign above_high = sync_reg[3];
    assign pwm_cmp = sync_reg[4];

    assign delay_done = (cnt_reg == CNT_W'(SET_CYCLES - 1));
    assign sense_done = (cnt_reg == CNT_W'(DET_CYCLES - 1));

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg + CNT_W'(1);
        case (state_reg)
            ST_OFF: begin
                cnt_next = '0;
                if (sup_good) begin
                    state_next = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (delay_done) begin
                    state_next = ST_SENSE;
                    cnt_next = '0;
                end
            end
            ST_SENSE: begin
                if (sense_done) begin
                    state_next = ST_RUN;
                    cnt_next = '0;
                end
            end
            ST_RUN: begin
                cnt_next = '0;
            end
            ST_FAULT: begin
                cnt_next = '0;
                if (!fb_short) begin
                    state_next = ST_DELAY;
                end
            end
            default: begin
                state_next = ST_OFF;
                cnt_next = '0;
            end
        endcase
        // Short seen anywhere after release restarts the whole sequence later
        if (fb_short && state_reg != ST_OFF) begin
            state_next = ST_FAULT;
            cnt_next = '0;
        end
        if (!sup_good) begin
            state_next = ST_OFF;
            cnt_next = '0;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state_reg <= ST_OFF;
            cnt_reg <= '0;
            sense_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            sense_reg <= (state_next == ST_SENSE);
        end
    end

    // Latch on the last window cycle while the current still flows
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            mode_reg <= MODE_SPREAD;
            mode_valid_reg <= 1'b0;
        end else if (state_reg == ST_SENSE && state_next == ST_RUN) begin
            mode_reg <= sfm_decode(above_low, above_high);
            mode_valid_reg <= 1'b1;
        end else if (state_next == ST_OFF || state_next == ST_FAULT) begin
            mode_valid_reg <= 1'b0;
        end
    end

    assign osc_link.mode = mode_reg;
    assign osc_link.run = (state_reg == ST_RUN);
    assign osc_link.line_lvl = sync_reg[12:5];
    assign osc_link.mult_lvl = sync_reg[20:13];

    sfm_osc u_osc (
        .clk(CLK),
        .rst(SYS_RST),
        .o(osc_link.osc)
    );

    // Reset side wins over a coincident set to avoid a runaway on-time
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            gate_reg <= 1'b0;
        end else if (state_reg != ST_RUN || inhibit_reg || fb_short) begin
            gate_reg <= 1'b0;
        end else if (pwm_cmp) begin
            gate_reg <= 1'b0;
        end else if (osc_link.set_pulse) begin
            gate_reg <= 1'b1;
        end
    end

    assign GATE_DRIVE = gate_reg;
    assign SENSE_CURRENT_EN = sense_reg;
    assign FREQ_MODE = mode_reg;

    // Interrupt events
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            sup_good_d_reg <= 1'b0;
        end else begin
            sup_good_d_reg <= sup_good;
        end
    end

    always_comb begin
        events = '0;
        events[EV_MODE_DONE] = (state_reg == ST_SENSE) && (state_next == ST_RUN);
        events[EV_FB_FAULT] = (state_reg != ST_FAULT) && (state_next == ST_FAULT);
        events[EV_LOCKOUT] = sup_good_d_reg && !sup_good;
    end

    assign wr_access = PSEL && PENABLE && PWRITE;
    assign rd_setup = PSEL && !PENABLE && !PWRITE;
    assign mapped = (PADDR == ADDR_CTRL) || (PADDR == ADDR_STATUS) ||
                    (PADDR == ADDR_INT_STAT) || (PADDR == ADDR_INT_MASK);

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            inhibit_reg <= 1'b0;
            int_mask_reg <= INT_MASK_RST;
        end else if (wr_access && PADDR == ADDR_CTRL) begin
            inhibit_reg <= PWDATA[CTRL_INHIBIT];
        end else if (wr_access && PADDR == ADDR_INT_MASK) begin
            int_mask_reg <= PWDATA[EV_W-1:0];
        end
    end

    // New events win over a write-one clear in the same cycle
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            int_stat_reg <= '0;
        end else if (wr_access && PADDR == ADDR_INT_STAT) begin
            int_stat_reg <= (int_stat_reg & ~PWDATA[EV_W-1:0]) | events;
        end else begin
            int_stat_reg <= int_stat_reg | events;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(int_stat_reg & int_mask_reg);
        end
    end

    assign IRQ = irq_reg;

    // Read data captured in the setup phase
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            prdata_reg <= '0;
        end else if (rd_setup) begin
            prdata_reg <= '0;
            case (PADDR)
                ADDR_CTRL: begin
                    prdata_reg[CTRL_INHIBIT] <= inhibit_reg;
                end
                ADDR_STATUS: begin
                    prdata_reg[ST_STATE_LSB +: 3] <= 3'(state_reg);
                    prdata_reg[ST_MODE_LSB +: 2] <= mode_reg;
                    prdata_reg[ST_MODE_VALID] <= mode_valid_reg;
                    prdata_reg[ST_GATE] <= gate_reg;
                    prdata_reg[ST_SUPPLY] <= sup_good;
                    prdata_reg[ST_FB_SHORT] <= fb_short;
                end
                ADDR_INT_STAT: begin
                    prdata_reg[EV_W-1:0] <= int_stat_reg;
                end
                ADDR_INT_MASK: begin
                    prdata_reg[EV_W-1:0] <= int_mask_reg;
                end
                default: begin
                    prdata_reg <= '0;
                end
            endcase
        end
    end

    assign PRDATA = prdata_reg;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !mapped;

    a_delay_len: assert property (@(posedge CLK) disable iff (SYS_RST)
        $rose(sense_reg) |-> $past(state_reg) == ST_DELAY && $past(cnt_reg) == SET_CYCLES - 1)
        else $error("sense started at wrong delay");
    a_sense_len: assert property (@(posedge CLK) disable iff (SYS_RST)
        $rose(mode_valid_reg) |-> $past(sense_reg) && $past(cnt_reg) == DET_CYCLES - 1)
        else $error("mode latched at wrong window end");
    a_mode_decode: assert property (@(posedge CLK) disable iff (SYS_RST)
        $rose(mode_valid_reg) |->
            mode_reg == ($past(above_high) ? MODE_60K : ($past(above_low) ? MODE_65K : MODE_SPREAD)))
        else $error("mode decode wrong");
    a_mode_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
        (state_reg == ST_RUN && $past(state_reg) == ST_RUN) |-> $stable(mode_reg))
        else $error("mode changed while running");
    a_gate_quiet: assert property (@(posedge CLK) disable iff (SYS_RST)
        (state_reg == ST_DELAY || state_reg == ST_SENSE) |=> !GATE_DRIVE)
        else $error("gate active during sequence");
    a_run_after: assert property (@(posedge CLK) disable iff (SYS_RST)
        $fell(sense_reg) && sup_good && !fb_short |-> state_reg == ST_RUN)
        else $error("switching did not follow sequence");
    a_lockout_off: assert property (@(posedge CLK) disable iff (SYS_RST)
        !sup_good |=> state_reg == ST_OFF ##1 !GATE_DRIVE)
        else $error("running under lockout");
    a_fault_stop: assert property (@(posedge CLK) disable iff (SYS_RST)
        (fb_short && state_reg == ST_RUN) |=> state_reg == ST_FAULT && !GATE_DRIVE)
        else $error("short did not stop gate");
    a_gate_set: assert property (@(posedge CLK) disable iff (SYS_RST)
        (osc_link.set_pulse && state_reg == ST_RUN && !inhibit_reg && !fb_short && !pwm_cmp)
            |=> GATE_DRIVE)
        else $error("set pulse missed");
    a_gate_reset: assert property (@(posedge CLK) disable iff (SYS_RST)
        pwm_cmp |=> !GATE_DRIVE)
        else $error("pwm reset missed");
    // Window end is the only place the mode may move
    a_mode_latch_only: assert property (@(posedge CLK) disable iff (SYS_RST)
        !(state_reg == ST_SENSE && state_next == ST_RUN) |=> $stable(mode_reg))
        else $error("mode moved outside window end");
    a_sense_no_gate: assert property (@(posedge CLK) disable iff (SYS_RST)
        SENSE_CURRENT_EN |-> !GATE_DRIVE)
        else $error("gate active while sensing");
    a_inhibit_gate: assert property (@(posedge CLK) disable iff (SYS_RST)
        inhibit_reg |=> !GATE_DRIVE)
        else $error("gate active while inhibited");
    a_event_sticky: assert property (@(posedge CLK) disable iff (SYS_RST)
        (|events) |=> (int_stat_reg & $past(events)) == $past(events))
        else $error("event lost against clear");
    a_irq_level: assert property (@(posedge CLK) disable iff (SYS_RST)
        IRQ == $past(|(int_stat_reg & int_mask_reg)))
        else $error("irq not following masked status");
endmodule

// *** sfm_pkg.sv ***
// Purpose: Shared constants and types for the start-up frequency mode strap block
// Assumes: CLK runs at 250 MHz; comparator levels arrive as digital pins
// Notes: All offsets, fields, reset values and timing counts live here
//
// Functional notes
// - Pick one of three switching modes from the gate-pin resistor to ground.
// - Run the mode sequence after every lockout release and every feedback-short clear.
// - Mode stays fixed once switching runs; never re-evaluated while operating.
// - After lockout release wait about 5.9 ms, then source sense current 530 us.
// - Delay from release to sense current lies in 4.1 to 7.7 ms.
// - Sense window lasts 420 to 640 us, 530 us nominal.
// - After feedback-short clears: wait, sense, then start switching.
// - During sensing compare pin voltage with 310 mV and 760 mV references.
// - Below low: spread; between: fixed 65 kHz; above high: fixed 60 kHz.
// - Gate enable stays off until the sequence ends, then switching starts.
// - Operate only after supply-good reports the lockout turn-on level passed.
// - Oscillator set pulse sets the gate flip-flop, driving the gate high.
// - PWM comparator trip resets the gate flip-flop until the next set pulse.
// - Spread mode varies switching frequency between 50 and 70 kHz.
// - Spread: near zero-crossing follow line sense; mid-phase fall with multiplier output.
// - Feedback below about 0.3 V stops gate pulses; they resume afterwards.
package sfm_pkg;

    localparam int CLK_MHZ = 250;
    localparam int CLK_KHZ = CLK_MHZ * 1000;
    localparam real SET_TIME_MS = 5.9;
    localparam real DET_TIME_US = 530.0;
    localparam int SET_CYC = int'(SET_TIME_MS * 1000.0 * CLK_MHZ);
    localparam int DET_CYC = int'(DET_TIME_US * CLK_MHZ);
    localparam int CNT_W = 21;

    localparam int FREQ_MIN_KHZ = 50;
    localparam int FREQ_MAX_KHZ = 70;
    localparam int FREQ_F1_KHZ = 60;
    localparam int FREQ_F2_KHZ = 65;
    localparam int PER_W = 13;
    localparam int PER_MAX = CLK_KHZ / FREQ_MIN_KHZ;
    localparam int PER_MIN = CLK_KHZ / FREQ_MAX_KHZ;
    localparam int PER_60K = CLK_KHZ / FREQ_F1_KHZ;
    localparam int PER_65K = CLK_KHZ / FREQ_F2_KHZ;
    localparam int PER_STEP = 5;
    localparam logic [7:0] LINE_MID_LVL = 8'h40;

    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_INT_STAT = 12'h008;
    localparam logic [11:0] ADDR_INT_MASK = 12'h00C;

    localparam int CTRL_INHIBIT = 0;
    localparam int ST_STATE_LSB = 0;
    localparam int ST_MODE_LSB = 4;
    localparam int ST_MODE_VALID = 6;
    localparam int ST_GATE = 7;
    localparam int ST_SUPPLY = 8;
    localparam int ST_FB_SHORT = 9;
    localparam int EV_MODE_DONE = 0;
    localparam int EV_FB_FAULT = 1;
    localparam int EV_LOCKOUT = 2;
    localparam int EV_W = 3;
    localparam logic [EV_W-1:0] INT_MASK_RST = 3'h0;

    typedef enum logic [1:0] {MODE_SPREAD, MODE_65K, MODE_60K} sfm_mode_t;
    typedef enum {ST_OFF, ST_DELAY, ST_SENSE, ST_RUN, ST_FAULT} sfm_state_t;

    function automatic sfm_mode_t sfm_decode(input logic above_low, input logic above_high);
        if (above_high) begin
            return MODE_60K;
        end else if (above_low) begin
            return MODE_65K;
        end
        return MODE_SPREAD;
    endfunction

endpackage

// *** sfm_osc_if.sv ***
// Purpose: Link between the start-up sequencer and the oscillator
// Assumes: One clock domain
// Notes: seq drives mode and run; osc answers with period and set pulse
`timescale 1ns/1ps
interface sfm_osc_if;
    import sfm_pkg::*;
    sfm_mode_t mode;
    logic run;
    logic [7:0] line_lvl;
    logic [7:0] mult_lvl;
    logic set_pulse;
    logic [PER_W-1:0] period;
    modport seq (output mode, run, line_lvl, mult_lvl, input set_pulse, period);
    modport osc (input mode, run, line_lvl, mult_lvl, output set_pulse, period);
endinterface

// *** sfm_osc.sv ***
// Purpose: Switching oscillator producing the gate set pulse
// Assumes: Levels on the link are already synchronised
// Notes: Counter held at zero while not running
`timescale 1ns/1ps
module sfm_osc
    import sfm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    sfm_osc_if.osc o
);
    logic [PER_W-1:0] per_cnt_reg;
    logic set_pulse_reg;
    logic [PER_W-1:0] per_next;

    always_comb begin
        per_next = PER_W'(PER_60K);
        case (o.mode)
            MODE_60K: begin
                per_next = PER_W'(PER_60K);
            end
            MODE_65K: begin
                per_next = PER_W'(PER_65K);
            end
            MODE_SPREAD: begin
                // Line low: near zero crossing, frequency rises with line level
                if (o.line_lvl < LINE_MID_LVL) begin
                    per_next = PER_W'(PER_MAX) - PER_W'(o.line_lvl * PER_STEP);
                end else begin
                    per_next = PER_W'(PER_MIN) + PER_W'(o.mult_lvl * PER_STEP);
                end
            end
            default: begin
                per_next = PER_W'(PER_60K);
            end
        endcase
    end

    assign o.period = per_next;
    assign o.set_pulse = set_pulse_reg;

    always_ff @(posedge clk) begin
        if (rst || !o.run) begin
            per_cnt_reg <= '0;
            set_pulse_reg <= 1'b0;
        end else if (per_cnt_reg >= per_next - PER_W'(1)) begin
            per_cnt_reg <= '0;
            set_pulse_reg <= 1'b1;
        end else begin
            per_cnt_reg <= per_cnt_reg + PER_W'(1);
            set_pulse_reg <= 1'b0;
        end
    end

    a_osc_range: assert property (@(posedge clk) disable iff (rst)
        o.run |-> (o.period >= PER_MIN && o.period <= PER_MAX))
        else $error("spread period out of range");
    a_osc_fixed: assert property (@(posedge clk) disable iff (rst)
        (o.mode == MODE_65K) |-> o.period == PER_65K)
        else $error("fixed 65k period wrong");
    a_osc_idle: assert property (@(posedge clk) disable iff (rst)
        !o.run |=> !o.set_pulse)
        else $error("set pulse while stopped");
endmodule

// *** sfm_pin_model.sv ***
// Purpose: Far side of the gate pin: mode resistor and power switch gate
// Assumes: Sense current into the resistor gives a fixed voltage per code
// Notes: Comparator levels settle a few cycles after the current starts
`timescale 1ns/1ps
module sfm_pin_model #(
    parameter int SETTLE = 2
)
(
    input wire logic clk,
    input wire logic sense_en,
    input wire logic gate,
    input wire logic [1:0] res_sel,
    output logic above_low,
    output logic above_high
);
    int settle_cnt = 0;
    int res_mv;
    int pin_mv;

    always @(posedge clk) begin
        settle_cnt <= sense_en ? ((settle_cnt < SETTLE) ? settle_cnt + 1 : settle_cnt) : 0;
    end

    always_comb begin
        case (res_sel)
            2'h0: res_mv = 150;
            2'h1: res_mv = 500;
            default: res_mv = 1200;
        endcase
        // Driven gate lifts the pin to the supply rail
        if (gate) begin
            pin_mv = 15000;
        end else if (sense_en && settle_cnt >= SETTLE) begin
            pin_mv = res_mv;
        end else begin
            pin_mv = 0;
        end
        above_low = pin_mv > 310;
        above_high = pin_mv > 760;
    end
endmodule

// *** sfm_startup_top_test.sv ***
// Purpose: Self-checking bench for the start-up mode strap block
// Assumes: Shortened delay and sense window counts
// Notes: Pin model stands in for the resistor and the switch gate
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %s exp=%0h got=%0h", n, e, g); end end
module sfm_startup_top_test;
    import sfm_pkg::*;
    localparam int SET_C = 20;
    localparam int DET_C = 10;
    logic CLK = 0;
    logic SYS_RST = 1;
    logic PSEL = 0;
    logic PENABLE = 0;
    logic PWRITE = 0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic [31:0] rd;
    logic PREADY, PSLVERR, err, PIN_ABOVE_LOW, PIN_ABOVE_HIGH;
    logic SUPPLY_GOOD = 0;
    logic FB_SHORT = 0;
    logic PWM_CMP = 0;
    logic GATE_DRIVE, SENSE_CURRENT_EN, IRQ;
    logic [7:0] LINE_SENSE = 8'h00;
    logic [7:0] MULT_OUT = 8'h00;
    logic [1:0] FREQ_MODE;
    logic [1:0] res_sel = 2'h0;
    int n_errors = 0;
    int comparisons = 0;
    int cyc = 0;

    always #2 CLK = ~CLK;

    sfm_startup_top #(.SET_CYCLES(SET_C), .DET_CYCLES(DET_C)) i_dut (.CLK(CLK),
        .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .SUPPLY_GOOD(SUPPLY_GOOD), .FB_SHORT(FB_SHORT),
        .PIN_ABOVE_LOW(PIN_ABOVE_LOW), .PIN_ABOVE_HIGH(PIN_ABOVE_HIGH),
        .PWM_CMP(PWM_CMP), .LINE_SENSE(LINE_SENSE), .MULT_OUT(MULT_OUT),
        .GATE_DRIVE(GATE_DRIVE), .SENSE_CURRENT_EN(SENSE_CURRENT_EN),
        .FREQ_MODE(FREQ_MODE), .IRQ(IRQ));

    sfm_pin_model i_pin (.clk(CLK), .sense_en(SENSE_CURRENT_EN), .gate(GATE_DRIVE),
        .res_sel(res_sel), .above_low(PIN_ABOVE_LOW), .above_high(PIN_ABOVE_HIGH));

    task automatic end_sim;
        if (n_errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge CLK) begin
        cyc++;
        if (cyc == 100000) begin
            n_errors++;
            end_sim;
        end
    end

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic seq_check(input logic [1:0] m);
        int n, w, g;
        n = 0;
        g = 0;
        while (SENSE_CURRENT_EN !== 1'b1 && n < 100) begin
            @(negedge CLK);
            n++;
            if (GATE_DRIVE !== 1'b0) g++;
        end
        `CHK("sense delay", 1'b1, n inside {[SET_C+1:SET_C+8]})
        w = 0;
        while (SENSE_CURRENT_EN === 1'b1 && w < 100) begin
            if (GATE_DRIVE !== 1'b0) g++;
            @(negedge CLK);
            w++;
        end
        `CHK("window length", DET_C, w)
        `CHK("gate idle in sequence", 0, g)
        `CHK("latched mode", m, FREQ_MODE)
        apb(ADDR_INT_STAT, 1'b0, 32'h0);
        `CHK("mode event", 1'b1, rd[EV_MODE_DONE])
    endtask

    // Period counted between gate rises, with a PWM trip in between
    task automatic measure(output int p);
        int n;
        n = 0;
        while (GATE_DRIVE !== 1'b1 && n < 6000) begin
            @(negedge CLK);
            n++;
        end
        `CHK("gate set", 1'b1, GATE_DRIVE)
        @(posedge CLK) PWM_CMP <= 1'b1;
        @(negedge CLK) p = 1;
        while (GATE_DRIVE === 1'b1 && p < 10) begin
            @(negedge CLK);
            p++;
        end
        `CHK("pwm trip gate", 1'b1, p <= 6)
        @(posedge CLK) PWM_CMP <= 1'b0;
        while (GATE_DRIVE !== 1'b1 && p < 6000) begin
            @(negedge CLK);
            p++;
        end
    endtask

    task automatic spread_p(input logic [7:0] line, input logic [7:0] mult, output int p);
        @(posedge CLK);
        LINE_SENSE <= line;
        MULT_OUT <= mult;
        measure(p);
        measure(p);
        `CHK("spread range", 1'b1, p inside {[PER_MIN-2:PER_MAX+2]})
    endtask

    task automatic t_reset;
        `CHK("gate at reset", 1'b0, GATE_DRIVE)
        `CHK("sense at reset", 1'b0, SENSE_CURRENT_EN)
        apb(ADDR_INT_MASK, 1'b0, 32'h0);
        `CHK("mask reset", 32'h0, rd)
        apb(ADDR_CTRL, 1'b0, 32'h0);
        `CHK("ctrl reset", 32'h0, rd)
        apb(12'h010, 1'b0, 32'h0);
        `CHK("unmapped error", 1'b1, err)
        apb(ADDR_INT_MASK, 1'b1, 32'h7);
        apb(ADDR_INT_MASK, 1'b0, 32'h0);
        `CHK("mask rw", 32'h7, rd)
        repeat (SET_C + 20) @(negedge CLK);
        `CHK("no sense without supply", 1'b0, SENSE_CURRENT_EN)
    endtask

    task automatic t_modes;
        for (int m = 0; m < 3; m++) begin
            @(posedge CLK);
            SUPPLY_GOOD <= 1'b0;
            res_sel <= 2'(m);
            repeat (6) @(negedge CLK);
            `CHK("lockout gate", 1'b0, GATE_DRIVE)
            apb(ADDR_INT_STAT, 1'b0, 32'h0);
            `CHK("lockout event", m != 0, rd[EV_LOCKOUT])
            apb(ADDR_INT_STAT, 1'b1, 32'h7);
            @(posedge CLK) SUPPLY_GOOD <= 1'b1;
            seq_check(2'(m));
            `CHK("irq on mode event", 1'b1, IRQ)
            apb(ADDR_INT_STAT, 1'b1, 32'h7);
            repeat (2) @(negedge CLK);
            `CHK("irq cleared", 1'b0, IRQ)
        end
    endtask

    task automatic t_run;
        int p;
        @(posedge CLK) res_sel <= 2'h0;
        measure(p);
        `CHK("mode kept", 2'(MODE_60K), FREQ_MODE)
        `CHK("fixed period", 1'b1, p inside {[PER_60K-2:PER_60K+2]})
        apb(ADDR_CTRL, 1'b1, 32'h1);
        repeat (2) @(negedge CLK);
        `CHK("inhibit gate", 1'b0, GATE_DRIVE)
        apb(ADDR_STATUS, 1'b0, 32'h0);
        `CHK("status run", 3'(ST_RUN), rd[ST_STATE_LSB +: 3])
        `CHK("status mode", {1'b1, 2'(MODE_60K)}, rd[ST_MODE_VALID:ST_MODE_LSB])
        apb(ADDR_CTRL, 1'b1, 32'h0);
    endtask

    task automatic t_fault;
        apb(ADDR_INT_MASK, 1'b1, 32'h1);
        apb(ADDR_INT_STAT, 1'b1, 32'h7);
        @(posedge CLK) FB_SHORT <= 1'b1;
        repeat (5) @(negedge CLK);
        `CHK("fault gate off", 1'b0, GATE_DRIVE)
        `CHK("masked irq", 1'b0, IRQ)
        apb(ADDR_INT_STAT, 1'b0, 32'h0);
        `CHK("fault event", 1'b1, rd[EV_FB_FAULT])
        repeat (SET_C + 20) @(negedge CLK);
        `CHK("no sense in fault", 1'b0, SENSE_CURRENT_EN)
        @(posedge CLK);
        res_sel <= 2'h1;
        FB_SHORT <= 1'b0;
        seq_check(2'(MODE_65K));
        apb(ADDR_INT_MASK, 1'b1, 32'h7);
    endtask

    task automatic t_spread;
        int p1, p2;
        @(posedge CLK);
        SUPPLY_GOOD <= 1'b0;
        res_sel <= 2'h0;
        repeat (6) @(negedge CLK);
        @(posedge CLK) SUPPLY_GOOD <= 1'b1;
        seq_check(2'(MODE_SPREAD));
        spread_p(8'h10, 8'h00, p1);
        spread_p(8'h30, 8'h00, p2);
        `CHK("line raises freq", 1'b1, p2 < p1)
        spread_p(8'h80, 8'h10, p1);
        spread_p(8'h80, 8'h60, p2);
        `CHK("mult lowers freq", 1'b1, p2 > p1)
    endtask

    initial begin
        repeat (16) @(posedge CLK);
        SYS_RST <= 1'b0;
        @(negedge CLK);
        t_reset;
        t_modes;
        t_run;
        t_fault;
        t_spread;
        end_sim;
    end
endmodule
